//--- design/ccpu_consts.vh
// constants for the capture/compare/pwm unit
`ifndef CCPU_CONSTS_VH
`define CCPU_CONSTS_VH

// register byte addresses
`define CCPU_ADDR_CTRL    8'h00
`define CCPU_ADDR_CAPLO   8'h04
`define CCPU_ADDR_CAPHI   8'h08
`define CCPU_ADDR_PERIOD  8'h0c
`define CCPU_ADDR_STATUS  8'h10

// control register fields
`define CCPU_MODE_MSB     3
`define CCPU_MODE_LSB     0
`define CCPU_DLOW_MSB     5
`define CCPU_DLOW_LSB     4
`define CCPU_CTRL_W       6

// status register fields
`define CCPU_ST_FLAG      0
`define CCPU_ST_IEN       1

// reset values
`define CCPU_CTRL_RST     6'h00
`define CCPU_BYTE_RST     8'h00
`define CCPU_PERIOD_RST   8'hff

// mode field encodings
`define CCPU_M_OFF        4'h0
`define CCPU_M_CAP_FALL   4'h4
`define CCPU_M_CAP_RISE   4'h5
`define CCPU_M_CAP_4TH    4'h6
`define CCPU_M_CAP_16TH   4'h7
`define CCPU_M_CMP_SET    4'h8
`define CCPU_M_CMP_CLR    4'h9
`define CCPU_M_CMP_SWI    4'ha
`define CCPU_M_CMP_SPEC   4'hb

// capture edge prescale terminal counts; 4th looks at the low two bits only
`define CCPU_PS4_LAST     2'h3
`define CCPU_PS16_LAST    4'hf

`endif

//--- design/ccpu_capture_compare_pwm.v
// capture/compare/pwm unit for one channel pin, with an apb register slave
`timescale 1ns/1ns
`default_nettype none
`include "ccpu_consts.vh"

module ccpu_capture_compare_pwm (
   input  wire        clock,          // system clock, 10 mhz
   input  wire        arst_n,         // asynchronous reset, active low
   input  wire        psel,           // apb select
   input  wire        penable,        // apb access phase
   input  wire        pwrite,         // apb write
   input  wire [7:0]  paddr,          // apb byte address
   input  wire [31:0] pwdata,         // apb write data
   output wire        pready,         // apb ready
   output reg  [31:0] prdata,         // apb read data
   output wire        pslverr,        // apb error on unmapped address
   input  wire        channelPinIn,   // pad level of the channel pin
   output reg         channelPinOut,  // level driven onto the channel pin
   output wire        channelPinOe,   // unit controls the pin
   input  wire [15:0] wideTimerCount, // shared 16-bit timer count
   input  wire        wideTimerTick,  // one-cycle pulse: wide timer clock edge
   output reg         wideTimerReset, // pulse: zero wide timer at this tick
   output reg         adcStart,       // pulse: special event trigger
   input  wire [7:0]  pwmTimerCount,  // 8-bit pwm timer count
   input  wire [1:0]  pwmTimerLow,    // two low time-base bits
   input  wire        pwmTimerTick,   // one-cycle pulse: pwm timer increment
   output reg         pwmTimerClear,  // pulse: clear pwm timer at this tick
   output wire [7:0]  pwmPeriod,      // period register for the pwm timer
   input  wire        sleepMode,      // device asleep, unit frozen
   output wire        channelIrqFlag, // channel interrupt request flag
   output wire        channelIrqReq   // flag gated by the channel enable
);

   ////////////////////////////////////////////////////////////////////////
   // mode decoding

   function isCapture;
      input [3:0] m;
      begin
         isCapture = (m[3:2] == 2'b01);
      end
   endfunction

   function isCompare;
      input [3:0] m;
      begin
         isCompare = (m[3:2] == 2'b10);
      end
   endfunction

   function isPwm;
      input [3:0] m;
      begin
         isPwm = (m[3:2] == 2'b11);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   reg  [5:0]  ctrl_reg;       // channel_control_reg
   reg  [7:0]  capLo_reg;      // capture_low_or_duty_msbs
   reg  [7:0]  capHi_reg;      // capture_high_or_active_duty
   reg  [7:0]  period_reg;     // pwm_period_reg
   reg         flag_reg;       // channel_irq_flag
   reg         irqEn_reg;      // channel_irq_enable

   // internal latches and pipelines
   reg  [1:0]  activeLow_reg;  // latched duty low bits
   reg  [3:0]  presc_reg;      // capture edge prescaler counter
   reg         pinSync1_reg;   // synchroniser first stage
   reg         pinSync2_reg;   // synchroniser second stage
   reg         pinPrev_reg;    // last synchronised level
   reg         matchPrev_reg;  // compare match seen last cycle
   reg         specPend_reg;   // timer reset waiting for tick
   reg         pinLevel_reg;   // compare output latch / pwm level

   // combinational decode results
   reg         irqSet;
   reg         capEvent;

   // mode and bus qualifiers
   wire [3:0]  mode = ctrl_reg[`CCPU_MODE_MSB:`CCPU_MODE_LSB];
   wire        run = ~sleepMode;
   wire        wrEn = psel & penable & pwrite;
   wire        addrOk;

   // one write strobe per register, taken in the access phase only
   wire        wrCtrl = wrEn & (paddr == `CCPU_ADDR_CTRL);
   wire        wrCapLo = wrEn & (paddr == `CCPU_ADDR_CAPLO);
   wire        wrCapHi = wrEn & (paddr == `CCPU_ADDR_CAPHI);
   wire        wrPeriod = wrEn & (paddr == `CCPU_ADDR_PERIOD);
   wire        wrStatus = wrEn & (paddr == `CCPU_ADDR_STATUS);

   // pin edges from the synchronised level
   wire        rise = pinSync2_reg & ~pinPrev_reg;
   wire        fall = ~pinSync2_reg & pinPrev_reg;

   // prescaler terminal counts; the counter wraps, so 4th uses two bits
   wire        ps4Last = (presc_reg[1:0] == `CCPU_PS4_LAST);
   wire        ps16Last = (presc_reg == `CCPU_PS16_LAST);

   // compare against the shared wide timer; a held match fires once
   wire        match = (wideTimerCount == {capHi_reg, capLo_reg});
   wire        matchNew = match & ~matchPrev_reg;

   // pwm period end and duty end on the 10-bit time base
   wire        periodHit = pwmTimerTick & (pwmTimerCount == period_reg);
   wire [9:0]  dutyBuf = {capLo_reg, ctrl_reg[`CCPU_DLOW_MSB:`CCPU_DLOW_LSB]};
   wire        dutyHit = ({pwmTimerCount, pwmTimerLow} == {capHi_reg, activeLow_reg});

   // single-cycle access phase; read data is prepared in setup
   assign pready = 1'b1;
   assign addrOk = (paddr == `CCPU_ADDR_CTRL) | (paddr == `CCPU_ADDR_CAPLO) |
                   (paddr == `CCPU_ADDR_CAPHI) | (paddr == `CCPU_ADDR_PERIOD) |
                   (paddr == `CCPU_ADDR_STATUS);
   assign pslverr = psel & penable & ~addrOk;

   // plain views of internal state
   assign pwmPeriod = period_reg;
   assign channelIrqFlag = flag_reg;
   assign channelIrqReq = flag_reg & irqEn_reg;

   // pin is the unit's only in set/clear compare and pwm; off frees it
   assign channelPinOe = (mode == `CCPU_M_CMP_SET) | (mode == `CCPU_M_CMP_CLR) |
                         isPwm(mode);

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser; the pad level is read back even when driven

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pinSync1_reg <= 1'b0;
         pinSync2_reg <= 1'b0;
      end else begin
         pinSync1_reg <= channelPinIn;
         // nothing but the second stage reads the first
         pinSync2_reg <= pinSync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture event selection

   always @* begin
      capEvent = 1'b0;
      case (mode)
         `CCPU_M_CAP_FALL: capEvent = fall;
         `CCPU_M_CAP_RISE: capEvent = rise;
         `CCPU_M_CAP_4TH:  capEvent = rise & ps4Last;
         `CCPU_M_CAP_16TH: capEvent = rise & ps16Last;
         default:          capEvent = 1'b0;
      endcase
   end

   // flag sources: captures and every compare match
   always @* begin
      irqSet = run & (capEvent | (isCompare(mode) & matchNew));
   end

   ////////////////////////////////////////////////////////////////////////
   // capture prescaler; a mode change inside capture keeps the count

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         presc_reg <= 4'h0;
         pinPrev_reg <= 1'b0;
      end else if (!isCapture(mode)) begin
         presc_reg <= 4'h0;
         pinPrev_reg <= pinSync2_reg;
      end else if (run) begin
         // awake only: sleep freezes the count and the edge memory
         pinPrev_reg <= pinSync2_reg;
         if (rise)
            presc_reg <= presc_reg + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare match tracking and special event trigger

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         matchPrev_reg <= 1'b0;
         specPend_reg <= 1'b0;
         wideTimerReset <= 1'b0;
         adcStart <= 1'b0;
      end else begin
         wideTimerReset <= 1'b0;
         adcStart <= 1'b0;
         if (run) begin
            matchPrev_reg <= match & isCompare(mode);
            if (mode != `CCPU_M_CMP_SPEC) begin
               specPend_reg <= 1'b0;
            end else if (matchNew) begin
               adcStart <= 1'b1;
               specPend_reg <= 1'b1;
            end else if (specPend_reg & !match) begin
               specPend_reg <= 1'b0;
            end else if (specPend_reg & wideTimerTick) begin
               // no overflow pulse is given, so the timer flag stays
               wideTimerReset <= 1'b1;
               specPend_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin latch: compare actions and pwm waveform

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pinLevel_reg <= 1'b0;
         activeLow_reg <= 2'b00;
         pwmTimerClear <= 1'b0;
      end else begin
         pwmTimerClear <= 1'b0;
         if (mode == `CCPU_M_OFF) begin
            pinLevel_reg <= 1'b0;
         end else if (run & isCompare(mode) & matchNew) begin
            // toggle has no encoding here, so only set and clear act
            if (mode == `CCPU_M_CMP_SET)
               pinLevel_reg <= 1'b1;
            else if (mode == `CCPU_M_CMP_CLR)
               pinLevel_reg <= 1'b0;
         end else if (run & isPwm(mode)) begin
            // a shared timer tick aligns rising edges of all channels
            if (periodHit) begin
               pwmTimerClear <= 1'b1;
               activeLow_reg <= dutyBuf[1:0];
               pinLevel_reg <= (dutyBuf != 10'h000);
            end else if (dutyHit) begin
               // a width beyond the period never matches, level stays
               pinLevel_reg <= 1'b0;
            end
         end
      end
   end

   // pin output follows the latch; sleep holds it since the latch freezes
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         channelPinOut <= 1'b0;
      else
         channelPinOut <= pinLevel_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers and hardware updates

   // control, period and enable: software only
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `CCPU_CTRL_RST;
         period_reg <= `CCPU_PERIOD_RST;
         irqEn_reg <= 1'b0;
      end else begin
         if (wrCtrl)
            ctrl_reg <= pwdata[`CCPU_CTRL_W-1:0];
         if (wrPeriod)
            period_reg <= pwdata[7:0];
         if (wrStatus)
            irqEn_reg <= pwdata[`CCPU_ST_IEN];
      end
   end

   // capture pair, shared as compare pair and as pwm duty buffer
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         capLo_reg <= `CCPU_BYTE_RST;
         capHi_reg <= `CCPU_BYTE_RST;
      end else begin
         if (wrCapLo)
            capLo_reg <= pwdata[7:0];
         if (run & isPwm(mode) & periodHit)
            capHi_reg <= dutyBuf[9:2];
         else if (wrCapHi & !isPwm(mode))
            capHi_reg <= pwdata[7:0];
         // a capture wins over a same-cycle software write
         if (capEvent & run) begin
            capHi_reg <= wideTimerCount[15:8];
            capLo_reg <= wideTimerCount[7:0];
         end
      end
   end

   // flag: set wins over a write-one-to-clear in the same cycle
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         flag_reg <= 1'b0;
      else if (irqSet)
         flag_reg <= 1'b1;
      else if (wrStatus & pwdata[`CCPU_ST_FLAG])
         flag_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, latched during the setup cycle

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h00000000;
      end else if (psel & !penable) begin
         // byte registers, upper bits read as zero
         case (paddr)
            `CCPU_ADDR_CTRL:   prdata <= {26'h0, ctrl_reg};
            `CCPU_ADDR_CAPLO:  prdata <= {24'h000000, capLo_reg};
            `CCPU_ADDR_CAPHI:  prdata <= {24'h000000, capHi_reg};
            `CCPU_ADDR_PERIOD: prdata <= {24'h000000, period_reg};
            `CCPU_ADDR_STATUS: prdata <= {30'h0, irqEn_reg, flag_reg};
            default:           prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

`default_nettype wire

//--- tb/ccpu_properties.sv
// concurrent checks on the capture/compare/pwm unit ports
`timescale 1ns/1ns
`default_nettype none
`include "ccpu_consts.vh"
module ccpu_properties (
   input wire logic        clock,          // system clock
   input wire logic        arst_n,         // async reset, low
   input wire logic        psel,           // apb select
   input wire logic        penable,        // apb access
   input wire logic        pwrite,         // apb write
   input wire logic [7:0]  paddr,          // apb address
   input wire logic [31:0] pwdata,         // apb write data
   input wire logic        pready,         // apb ready
   input wire logic        pslverr,        // apb error
   input wire logic        channelPinOut,  // pin level
   input wire logic        channelPinOe,   // pin owned
   input wire logic        wideTimerTick,  // wide timer edge
   input wire logic        wideTimerReset, // wide timer zero
   input wire logic        adcStart,       // special trigger
   input wire logic [7:0]  pwmTimerCount,  // pwm timer
   input wire logic        pwmTimerTick,   // pwm increment
   input wire logic        pwmTimerClear,  // pwm timer zero
   input wire logic [7:0]  pwmPeriod,      // period reg
   input wire logic        sleepMode,      // frozen
   input wire logic        channelIrqFlag  // channel flag
);
   ////////////////////////////////////////////////////////////
   // bus decode and timer wrap seen from the pins
   wire acc     = psel & penable;
   wire perWr   = acc & pwrite & (paddr == `CCPU_ADDR_PERIOD);
   wire flagClr = acc & pwrite & (paddr == `CCPU_ADDR_STATUS) & pwdata[0];
   wire perWrap = pwmTimerTick & (pwmTimerCount == pwmPeriod);
   wire mapped  = paddr == `CCPU_ADDR_CTRL || paddr == `CCPU_ADDR_CAPLO
               || paddr == `CCPU_ADDR_CAPHI || paddr == `CCPU_ADDR_PERIOD
               || paddr == `CCPU_ADDR_STATUS;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_err_map: assert property (acc |-> pslverr == !mapped)
      else $error("pslverr does not match decode");
   chk_adc_pulse: assert property (adcStart |=> !adcStart)
      else $error("trigger longer than one cycle");
   chk_adc_flag: assert property (adcStart |-> channelIrqFlag && !channelPinOe)
      else $error("trigger without flag or with pin owned");
   chk_reset_tick: assert property (wideTimerReset |-> $past(wideTimerTick))
      else $error("timer zero not on a timer edge");
   chk_clear_cause: assert property (pwmTimerClear |-> $past(perWrap))
      else $error("pwm clear without period match");
   chk_period_hold: assert property ($changed(pwmPeriod) |-> $past(perWr))
      else $error("period changed without write");
   chk_flag_sticky: assert property (channelIrqFlag && !flagClr |=> channelIrqFlag)
      else $error("flag dropped by itself");
   chk_sleep_hold: assert property (sleepMode[*3] |-> $stable(channelPinOut))
      else $error("pin moved while asleep");
   cover property (adcStart);
   cover property (wideTimerReset);
   cover property (pwmTimerClear);
endmodule
bind ccpu_capture_compare_pwm ccpu_properties u_chk (.clock(clock), .arst_n(arst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .channelPinOut(channelPinOut),
   .channelPinOe(channelPinOe), .wideTimerTick(wideTimerTick),
   .wideTimerReset(wideTimerReset), .adcStart(adcStart), .pwmTimerCount(pwmTimerCount),
   .pwmTimerTick(pwmTimerTick), .pwmTimerClear(pwmTimerClear), .pwmPeriod(pwmPeriod),
   .sleepMode(sleepMode), .channelIrqFlag(channelIrqFlag));
`default_nettype wire

//--- tb/ccpu_pin_partner.sv
// channel pin pad: outside source plus readback of the unit drive
`timescale 1ns/1ns
`default_nettype none
module ccpu_pin_partner (
   input  wire logic extLevel, // outside source level
   input  wire logic pinOe,    // unit drives the pad
   input  wire logic pinOut,   // unit drive level
   output logic      padLevel  // level seen at the pad
);
   // unit drive wins, the outside source is weak
   assign padLevel = pinOe ? pinOut : extLevel;
endmodule
`default_nettype wire

//--- tb/ccpu_capture_compare_pwm_tb.sv
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/1ns
`default_nettype none
`include "ccpu_consts.vh"
module ccpu_capture_compare_pwm_tb;
   logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, pwmTimerCount = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic        extLevel = 0, wideRun = 0, pwmRun = 0, wideTimerTick = 0, pwmTimerTick = 0;
   logic        sleepMode = 0, er = 0, seenRst = 0, nz;
   logic [15:0] capVal = 16'h0000, wtc = 16'h0000;
   logic [1:0]  pwmTimerLow = 2'h0;
   logic [3:0]  modes [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
   int          edges [4] = '{1, 1, 4, 16};
   int          fails = 0, nTests = 0, h1, h2, p;
   wire  [15:0] wideTimerCount = wideRun ? wtc : capVal;
   wire  [31:0] prdata;
   wire  [7:0]  pwmPeriod;
   wire         pready, pslverr, padLevel, channelPinOut, channelPinOe, wideTimerReset;
   wire         adcStart, pwmTimerClear, channelIrqFlag, channelIrqReq;
   always #50 clock = ~clock;
   ////////////////////////////////////////////////////////////
   // outside timers, synchronous to the system clock
   always @(posedge clock) begin
      wideTimerTick <= wideRun & ~wideTimerTick;
      seenRst <= seenRst | wideTimerReset;
      if (wideTimerReset || wtc == 16'h003f) wtc <= 16'h0000;
      else if (wideTimerTick) wtc <= wtc + 16'h0001;
      pwmTimerTick <= !sleepMode && pwmTimerLow == 2'h2;
      if (!sleepMode) begin
         pwmTimerLow <= pwmTimerLow + 2'h1;
         // a stopped timer sits at zero, so the first period starts clean
         if (!pwmRun || pwmTimerClear) pwmTimerCount <= 8'h00;
         else if (pwmTimerTick) pwmTimerCount <= pwmTimerCount + 8'h01;
      end
   end
   ccpu_capture_compare_pwm u_ccpu_capture_compare_pwm (.clock(clock), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .channelPinIn(padLevel),
      .channelPinOut(channelPinOut), .channelPinOe(channelPinOe),
      .wideTimerCount(wideTimerCount), .wideTimerTick(wideTimerTick),
      .wideTimerReset(wideTimerReset), .adcStart(adcStart), .pwmTimerCount(pwmTimerCount),
      .pwmTimerLow(pwmTimerLow), .pwmTimerTick(pwmTimerTick), .pwmTimerClear(pwmTimerClear),
      .pwmPeriod(pwmPeriod), .sleepMode(sleepMode), .channelIrqFlag(channelIrqFlag),
      .channelIrqReq(channelIrqReq));
   ccpu_pin_partner u_ccpu_pin_partner (.extLevel(extLevel), .pinOe(channelPinOe),
      .pinOut(channelPinOut), .padLevel(padLevel));
   ////////////////////////////////////////////////////////////
   // apb master: hold the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(n, e, rd);
   endtask
   // pad pulses long enough to pass the synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         extLevel <= 1'b1;
         repeat (4) @(posedge clock);
         extLevel <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask
   // high time and period of one pwm cycle, capped at 100
   task automatic measure(output int hi, output int per);
      for (int i = 0; i < 100 && channelPinOut !== 1'b0; i++) @(posedge clock);
      for (int i = 0; i < 100 && channelPinOut !== 1'b1; i++) @(posedge clock);
      hi = 1;
      per = 1;
      @(posedge clock);
      while (channelPinOut === 1'b1 && hi < 100) begin
         hi++;
         per++;
         @(posedge clock);
      end
      while (channelPinOut !== 1'b1 && per < 100) begin
         per++;
         @(posedge clock);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      rdchk("ctrl", `CCPU_ADDR_CTRL, 32'h0);
      rdchk("caphi", `CCPU_ADDR_CAPHI, 32'h0);
      rdchk("period", `CCPU_ADDR_PERIOD, 32'hff);
      rdchk("unmapped", 8'h14, 32'h0);
      check("slverr", 32'h1, er);
      // each capture setting: off first, then edges that must not capture
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `CCPU_ADDR_CTRL, 32'h0);
         apb(1'b1, `CCPU_ADDR_STATUS, 32'h1);
         apb(1'b1, `CCPU_ADDR_CTRL, {28'h0, modes[i]});
         capVal <= 16'haaaa;
         pulse(edges[i] - 1);
         rdchk("early flag", `CCPU_ADDR_STATUS, 32'h0);
         capVal <= 16'h1230 + 16'(i);
         pulse(1);
         rdchk("cap hi", `CCPU_ADDR_CAPHI, 32'h12);
         rdchk("cap lo", `CCPU_ADDR_CAPLO, 32'h30 + 32'(i));
         rdchk("cap flag", `CCPU_ADDR_STATUS, 32'h1);
      end
      // unread capture is overwritten; enable gates the request
      apb(1'b1, `CCPU_ADDR_CTRL, 32'h0);
      apb(1'b1, `CCPU_ADDR_CTRL, {28'h0, `CCPU_M_CAP_RISE});
      capVal <= 16'h0bbb;
      pulse(1);
      capVal <= 16'h0ccc;
      pulse(1);
      rdchk("overwrite", `CCPU_ADDR_CAPLO, 32'hcc);
      apb(1'b1, `CCPU_ADDR_STATUS, 32'h2);
      @(negedge clock);
      check("irq req", 32'h1, channelIrqReq);
      apb(1'b1, `CCPU_ADDR_CAPHI, 32'h0);
      apb(1'b1, `CCPU_ADDR_CAPLO, 32'h20);
      wideRun <= 1'b1;
      // every compare action against a running timer; clear follows set
      // directly, so that it has a high pin to drop
      for (int i = 0; i < 4; i++) begin
         if (i != 1) apb(1'b1, `CCPU_ADDR_CTRL, 32'h0);
         apb(1'b1, `CCPU_ADDR_STATUS, 32'h1);
         @(negedge clock);
         check("oe off", {31'h0, i == 1}, channelPinOe);
         check("flag off", 32'h0, channelIrqFlag);
         apb(1'b1, `CCPU_ADDR_CTRL, {28'h0, modes[i + 4]});
         for (int k = 0; k < 300 && channelIrqFlag !== 1'b1; k++) @(posedge clock);
         repeat (3) @(negedge clock);
         check("cmp flag", 32'h1, channelIrqFlag);
         check("cmp oe", {31'h0, i < 2}, channelPinOe);
         check("cmp pin", {31'h0, i == 0}, channelPinOut);
      end
      check("timer zeroed", 32'h1, seenRst);
      // pwm: period 3, duty 6 then 10 quarter steps
      apb(1'b1, `CCPU_ADDR_CTRL, 32'h0);
      wideRun <= 1'b0;
      apb(1'b1, `CCPU_ADDR_PERIOD, 32'h3);
      apb(1'b1, `CCPU_ADDR_CAPLO, 32'h1);
      apb(1'b1, `CCPU_ADDR_CTRL, 32'h2c);
      pwmRun <= 1'b1;
      measure(h1, p);
      check("pwm period", 32'd16, 32'(p));
      apb(1'b1, `CCPU_ADDR_CAPHI, 32'h55);
      rdchk("active duty", `CCPU_ADDR_CAPHI, 32'h1);
      apb(1'b1, `CCPU_ADDR_CAPLO, 32'h2);
      measure(h2, p);
      check("duty step", 32'd4, 32'(h2 - h1));
      sleepMode <= 1'b1;
      repeat (30) @(negedge clock);
      check("sleep pin", 32'h1, channelPinOut);
      @(posedge clock);
      sleepMode <= 1'b0;
      apb(1'b1, `CCPU_ADDR_CAPLO, 32'hff);
      measure(h1, p);
      check("wide duty", 32'd100, 32'(h1));
      apb(1'b1, `CCPU_ADDR_CAPLO, 32'h0);
      apb(1'b1, `CCPU_ADDR_CTRL, 32'h0c);
      repeat (40) @(negedge clock);
      nz = 1'b0;
      repeat (20) @(negedge clock) nz |= channelPinOut;
      check("zero duty", 32'h0, nz);
      final_report;
   end
endmodule
`default_nettype wire
